// File: hdl/rdpu_pkg.sv
package rdpu_pkg;
  // ==========================================================================
  // sizes
  localparam int          RDPU_ENTRIES    = 8;
  localparam int          RDPU_DW         = 32;
  localparam int          RDPU_IW         = 3;
  localparam int          RDPU_OW         = 10;
  // ==========================================================================
  // register window and offsets (byte addresses, one word each)
  localparam logic [31:0] RDPU_BASE       = 32'h40008400;
  localparam logic [31:0] RDPU_LAST       = 32'h400087FF;
  localparam logic [9:0]  RDPU_OFS_VALID  = 10'h040;
  localparam logic [9:0]  RDPU_OFS_DIS    = 10'h044;
  localparam logic [9:0]  RDPU_OFS_ENA    = 10'h048;
  // entry pair n: match address at 8*n, substitute data at 8*n+4
  localparam int          RDPU_DSEL_BIT   = 2;
  localparam int          RDPU_IDX_LSB    = 3;
  // ==========================================================================
  // bus encodings
  localparam int          RDPU_TRANS_BIT  = 1;
  localparam logic        RDPU_RESP_OKAY  = 1'b0;
  localparam logic        RDPU_READY      = 1'b1;
  localparam logic [31:0] RDPU_ZERO_WORD  = 32'h00000000;
  // ==========================================================================
  // whole state of the unit
  typedef struct packed {
    logic [RDPU_ENTRIES-1:0][RDPU_DW-1:0] matchAddr;
    logic [RDPU_ENTRIES-1:0][RDPU_DW-1:0] dataWord;
    logic [RDPU_ENTRIES-1:0]              valid;
    logic [RDPU_ENTRIES-1:0]              armed;
    logic [RDPU_ENTRIES-1:0]              loaded;
    logic                                 wrPend;
    logic [RDPU_OW-1:0]                   wrOfs;
    logic [RDPU_DW-1:0]                   rdWord;
    logic                                 romPend;
    logic                                 patchHit;
    logic [RDPU_DW-1:0]                   patchWord;
  } rdpu_state_t;

  localparam rdpu_state_t RDPU_STATE_RST = '0;
endpackage : rdpu_pkg

// File: hdl/rdpu_core.sv
`timescale 1ns/100ps
// Operation
// - eight entries, each a 32-bit match address and 32-bit substitute word pair.
// - valid bit of an entry sets itself once address then data are written.
// - bus address compared against all eight stored addresses at once.
// - enabled matching entry replaces returned ROM data with its substitute word.
// - among several matching entries the highest numbered one wins.
// - writing one to a disable strobe bit turns that entry off.
// - writing one to an enable strobe bit turns a loaded entry back on.
// - registers reached by plain bus register accesses.
// - substitution acts only on data coming back from the ROM controller.
// - registers decode only within 0x40008400 to 0x400087FF.
module rdpu_core (
  input  wire logic                         mclk,
  input  wire logic                         rst_b,
  input  wire logic                         hsel,
  input  wire logic [rdpu_pkg::RDPU_DW-1:0] haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [rdpu_pkg::RDPU_DW-1:0] hwdata,
  input  wire logic                         hready,
  output logic      [rdpu_pkg::RDPU_DW-1:0] hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  input  wire logic                         romSel,
  input  wire logic [rdpu_pkg::RDPU_DW-1:0] romHrdata,
  output logic      [rdpu_pkg::RDPU_DW-1:0] patchedRdata
);
  import rdpu_pkg::*;

  // ==========================================================================
  // offset decoding
  function automatic logic isEntry(input logic [RDPU_OW-1:0] ofs);
    isEntry = (ofs < RDPU_OFS_VALID);
  endfunction : isEntry

  function automatic logic [RDPU_IW-1:0] entryIdx(input logic [RDPU_OW-1:0] ofs);
    entryIdx = ofs[RDPU_IDX_LSB +: RDPU_IW];
  endfunction : entryIdx

  // ==========================================================================
  // state
  rdpu_state_t s;
  rdpu_state_t next_s;

  logic regAcc;
  logic romAcc;
  logic inWindow;
  logic busActive;
  logic [RDPU_OW-1:0] addrOfs;

  // address phase qualification; hsize is ignored, every write stores a full word
  assign busActive = hready & htrans[RDPU_TRANS_BIT];
  assign inWindow  = (haddr >= RDPU_BASE) && (haddr <= RDPU_LAST);
  assign regAcc    = busActive & hsel & inWindow;
  assign romAcc    = busActive & romSel & ~hwrite;
  assign addrOfs   = haddr[RDPU_OW-1:0];

  // next state: write data phase first, so a read or match right behind it sees the new value
  always_comb begin
    logic [RDPU_IW-1:0] wi;
    logic [RDPU_IW-1:0] ri;
    next_s = s;
    wi     = entryIdx(s.wrOfs);
    ri     = entryIdx(addrOfs);
    if (s.wrPend) begin
      if (isEntry(s.wrOfs)) begin
        if (!s.wrOfs[RDPU_DSEL_BIT]) begin
          // a new address re-arms the pair and withdraws the old patch
          next_s.matchAddr[wi] = hwdata;
          next_s.armed[wi]     = 1'b1;
          next_s.valid[wi]     = 1'b0;
          next_s.loaded[wi]    = 1'b0;
        end else begin
          next_s.dataWord[wi] = hwdata;
          if (s.armed[wi]) begin
            next_s.valid[wi]  = 1'b1;
            next_s.loaded[wi] = 1'b1;
            next_s.armed[wi]  = 1'b0;
          end
        end
      end else if (s.wrOfs == RDPU_OFS_DIS) begin
        next_s.valid = s.valid & ~hwdata[RDPU_ENTRIES-1:0];
      end else if (s.wrOfs == RDPU_OFS_ENA) begin
        // only a pair completed since its last address write may come back on
        next_s.valid = s.valid | (hwdata[RDPU_ENTRIES-1:0] & s.loaded);
      end
    end
    if (hready) begin
      next_s.wrPend = regAcc & hwrite;
      next_s.wrOfs  = addrOfs;
      next_s.rdWord = RDPU_ZERO_WORD;
      if (regAcc && !hwrite) begin
        if (isEntry(addrOfs)) begin
          next_s.rdWord = addrOfs[RDPU_DSEL_BIT] ? next_s.dataWord[ri] : next_s.matchAddr[ri];
        end else if (addrOfs == RDPU_OFS_VALID) begin
          next_s.rdWord = {{(RDPU_DW-RDPU_ENTRIES){1'b0}}, next_s.valid};
        end
      end
      next_s.romPend   = romAcc;
      next_s.patchHit  = 1'b0;
      next_s.patchWord = RDPU_ZERO_WORD;
      // eight parallel compares; later entries overwrite earlier ones
      for (int i = 0; i < RDPU_ENTRIES; i++) begin
        if (romAcc && next_s.valid[i] && (next_s.matchAddr[i] == haddr)) begin
          next_s.patchHit  = 1'b1;
          next_s.patchWord = next_s.dataWord[i];
        end
      end
    end else begin
      next_s.wrPend = 1'b0;
    end
  end

  // state register; power-down loses all entries
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RDPU_STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================================
  // outputs
  // the mux sits behind the ROM slave only, so other slaves' data never passes here
  assign patchedRdata = (s.romPend && s.patchHit) ? s.patchWord : romHrdata;
  assign hrdata       = s.rdWord;
  // registers never stall and never fail
  assign hreadyout    = RDPU_READY;
  assign hresp        = RDPU_RESP_OKAY;

  // ==========================================================================
  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  logic [RDPU_IW-1:0] wrIdx;
  logic [RDPU_IW-1:0] hiIdx;
  logic               hiMatch;
  logic               anyMatch;

  assign wrIdx = entryIdx(s.wrOfs);

  // reference priority search from the top, independent of the overwrite loop
  always_comb begin
    hiIdx    = '0;
    hiMatch  = 1'b0;
    anyMatch = 1'b0;
    for (int i = RDPU_ENTRIES - 1; i >= 0; i--) begin
      if (!hiMatch && s.valid[i] && s.matchAddr[i] == haddr) begin
        hiIdx   = RDPU_IW'(i);
        hiMatch = 1'b1;
      end
    end
    anyMatch = hiMatch;
  end

  sequence q_data_write_armed;
    s.wrPend && isEntry(s.wrOfs) && s.wrOfs[RDPU_DSEL_BIT] && s.armed[wrIdx];
  endsequence
  sequence q_rom_read_quiet;
    romAcc && !s.wrPend;
  endsequence

  property p_auto_valid;
    q_data_write_armed |=> s.valid[$past(wrIdx)] && s.loaded[$past(wrIdx)];
  endproperty
  a_auto_valid: assert property (p_auto_valid) else $error("entry not validated after data write");

  property p_addr_first;
    (s.wrPend && isEntry(s.wrOfs) && !s.wrOfs[RDPU_DSEL_BIT]) |=> s.armed[$past(wrIdx)] && !s.valid[$past(wrIdx)];
  endproperty
  a_addr_first: assert property (p_addr_first) else $error("address write did not arm entry");

  property p_disable;
    (s.wrPend && s.wrOfs == RDPU_OFS_DIS) |=> (s.valid & $past(hwdata[RDPU_ENTRIES-1:0])) == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("disable strobe left entry on");

  property p_enable;
    (s.wrPend && s.wrOfs == RDPU_OFS_ENA) |=>
      (s.valid & $past(hwdata[RDPU_ENTRIES-1:0]) & s.loaded) == ($past(hwdata[RDPU_ENTRIES-1:0]) & s.loaded);
  endproperty
  a_enable: assert property (p_enable) else $error("enable strobe did not restore entry");

  property p_valid_needs_load;
    (s.valid & ~s.loaded) == '0;
  endproperty
  a_valid_needs_load: assert property (p_valid_needs_load) else $error("valid entry never loaded");

  property p_priority;
    (q_rom_read_quiet and hiMatch) |=> ##0 patchedRdata == $past(s.dataWord[hiIdx]);
  endproperty
  a_priority: assert property (p_priority) else $error("wrong entry substituted");

  property p_no_match_passes;
    (q_rom_read_quiet and !anyMatch) |=> patchedRdata == romHrdata;
  endproperty
  a_no_match_passes: assert property (p_no_match_passes) else $error("rom data altered without match");

  property p_rom_only;
    !s.romPend |-> patchedRdata == romHrdata;
  endproperty
  a_rom_only: assert property (p_rom_only) else $error("substitution outside rom data phase");

  property p_window;
    (busActive && hsel && !inWindow) |=> hrdata == RDPU_ZERO_WORD && !s.wrPend;
  endproperty
  a_window: assert property (p_window) else $error("access outside window decoded");

  property p_readback_valid;
    (regAcc && !hwrite && addrOfs == RDPU_OFS_VALID && !s.wrPend) |=>
      hrdata[RDPU_ENTRIES-1:0] == s.valid && hreadyout && hresp == RDPU_RESP_OKAY;
  endproperty
  a_readback_valid: assert property (p_readback_valid) else $error("valid flags read back wrong");

  // ==========================================================================
  // storage, read path and strobe checks
  // these watch the stored words directly, so a wrong index shows even when no rom fetch follows
  logic [RDPU_IW-1:0] rdIdx;

  assign rdIdx = entryIdx(addrOfs);

  sequence q_addr_word_write;
    s.wrPend && isEntry(s.wrOfs) && !s.wrOfs[RDPU_DSEL_BIT];
  endsequence
  sequence q_data_word_write;
    s.wrPend && isEntry(s.wrOfs) && s.wrOfs[RDPU_DSEL_BIT];
  endsequence
  sequence q_entry_read_quiet;
    regAcc && !hwrite && isEntry(addrOfs) && !s.wrPend;
  endsequence

  // first edge after reset: empty table, nothing pending, so the first rom fetch is never patched
  property p_reset_empty;
    $rose(rst_b) |->
      s.valid == '0 && s.loaded == '0 && !s.wrPend && !s.romPend && hrdata == RDPU_ZERO_WORD;
  endproperty
  a_reset_empty: assert property (p_reset_empty) else $error("table not empty after reset");

  property p_store_addr;
    q_addr_word_write |=> s.matchAddr[$past(wrIdx)] == $past(hwdata);
  endproperty
  a_store_addr: assert property (p_store_addr) else $error("match address word not stored");

  property p_store_data;
    q_data_word_write |=> s.dataWord[$past(wrIdx)] == $past(hwdata);
  endproperty
  a_store_data: assert property (p_store_data) else $error("substitute word not stored");

  // a lone data word swaps the patch word but must not switch the entry on or off
  property p_lone_data_word;
    (q_data_word_write and !s.armed[wrIdx]) |=> s.valid[$past(wrIdx)] == $past(s.valid[wrIdx]);
  endproperty
  a_lone_data_word: assert property (p_lone_data_word) else $error("lone data word toggled entry");

  // no write in flight, so the table seen at the next edge is the one that was read
  property p_entry_readback;
    q_entry_read_quiet |=>
      hrdata == ($past(addrOfs[RDPU_DSEL_BIT]) ? s.dataWord[$past(rdIdx)] : s.matchAddr[$past(rdIdx)]);
  endproperty
  a_entry_readback: assert property (p_entry_readback) else $error("entry word read back wrong");

  // anything but a register read leaves zero on the read bus, so stale words never leak
  property p_idle_read_zero;
    (hready && !(regAcc && !hwrite)) |=> hrdata == RDPU_ZERO_WORD;
  endproperty
  a_idle_read_zero: assert property (p_idle_read_zero) else $error("read data left on the bus");

  property p_strobe_reads_zero;
    (regAcc && !hwrite && (addrOfs == RDPU_OFS_DIS || addrOfs == RDPU_OFS_ENA)) |=>
      hrdata == RDPU_ZERO_WORD;
  endproperty
  a_strobe_reads_zero: assert property (p_strobe_reads_zero) else $error("write-only strobe read back");

  // without a decoded register write the table must not move, whatever the bus does
  property p_quiet_keeps_table;
    !s.wrPend |=> s.valid == $past(s.valid) && s.matchAddr == $past(s.matchAddr)
                  && s.dataWord == $past(s.dataWord);
  endproperty
  a_quiet_keeps_table: assert property (p_quiet_keeps_table) else $error("table moved without write");

  // a write towards the rom has no read data to patch
  property p_rom_write_passes;
    (busActive && romSel && hwrite) |=> patchedRdata == romHrdata;
  endproperty
  a_rom_write_passes: assert property (p_rom_write_passes) else $error("rom write data phase patched");

  // zero bits of a strobe word must leave their entries exactly as they were
  property p_disable_spares_rest;
    (s.wrPend && s.wrOfs == RDPU_OFS_DIS) |=>
      (s.valid & ~$past(hwdata[RDPU_ENTRIES-1:0])) == ($past(s.valid) & ~$past(hwdata[RDPU_ENTRIES-1:0]));
  endproperty
  a_disable_spares_rest: assert property (p_disable_spares_rest) else $error("disable strobe spilled");

  property p_enable_spares_rest;
    (s.wrPend && s.wrOfs == RDPU_OFS_ENA) |=>
      (s.valid & ~$past(hwdata[RDPU_ENTRIES-1:0])) == ($past(s.valid) & ~$past(hwdata[RDPU_ENTRIES-1:0]));
  endproperty
  a_enable_spares_rest: assert property (p_enable_spares_rest) else $error("enable strobe spilled");

endmodule : rdpu_core

// File: bench/rdpu_rom_model.sv
`timescale 1ns/100ps
// ==========================================================================
// rom controller stand-in: word is the inverted address
module rdpu_rom_model (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        romSel,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic        hready,
  input  wire logic [31:0] haddr,
  output logic      [31:0] romHrdata
);
  logic        dataPhase;
  logic [31:0] lastAddr;
  logic [31:0] idleCnt;
  // idle pattern moves every cycle so stale data never passes for a hit
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dataPhase <= 1'b0;
      lastAddr  <= 32'h00000000;
      idleCnt   <= 32'h00000000;
    end else begin
      if (hready) begin
        dataPhase <= romSel && htrans[1] && !hwrite;
        lastAddr  <= haddr;
      end
      idleCnt <= idleCnt + 32'h00000001;
    end
  end
  assign romHrdata = dataPhase ? ~lastAddr : idleCnt;
endmodule : rdpu_rom_model

// File: bench/rom_data_patch_unit_bench.sv
`timescale 1ns/100ps
module rom_data_patch_unit_bench;
  import rdpu_pkg::*;
  logic        mclk = 0, rst_b = 0, hsel = 0, hwrite = 0, romSel = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, romHrdata, patchedRdata;
  logic        hreadyout, hresp;
  logic [31:0] addrs [8];
  logic [31:0] datas [8];
  logic [7:0]  validExp, m;
  int          error_cnt = 0, compares = 0, seed = 60, cycles = 0;
  // ==========================================================================
  // design and rom stand-in; hready and hsize tied, unit never stalls
  rdpu_core DUT (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(1'b1), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .romSel(romSel), .romHrdata(romHrdata),
    .patchedRdata(patchedRdata));
  rdpu_rom_model rom (.mclk(mclk), .rst_b(rst_b), .romSel(romSel), .htrans(htrans),
    .hwrite(hwrite), .hready(1'b1), .haddr(haddr), .romHrdata(romHrdata));
  always #5 mclk = ~mclk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  // ==========================================================================
  // tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one transfer: address phase, then data phase; outputs settled on return
  task automatic bus(input logic rom, input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1;
    hsel = !rom;
    romSel = rom;
    htrans = 2'h2;
    hwrite = wr;
    haddr = a;
    @(posedge mclk);
    #1;
    hsel = 0;
    romSel = 0;
    htrans = 2'h0;
    hwrite = 0;
    hwdata = d;
    check({30'h00000000, hresp, hreadyout}, {30'h00000000, RDPU_RESP_OKAY, RDPU_READY});
  endtask : bus
  task automatic wr(input logic [9:0] ofs, input logic [31:0] d);
    bus(1'b0, 1'b1, RDPU_BASE + {22'h000000, ofs}, d);
  endtask : wr
  task automatic rdReg(input logic [9:0] ofs, input logic [31:0] exp);
    bus(1'b0, 1'b0, RDPU_BASE + {22'h000000, ofs}, 32'h00000000);
    check(hrdata, exp);
  endtask : rdReg
  task automatic romRd(input logic [31:0] a);
    bus(1'b1, 1'b0, a, 32'h00000000);
    check(patchedRdata, expRom(a));
  endtask : romRd
  // highest enabled matching entry wins, else the rom word
  function automatic logic [31:0] expRom(input logic [31:0] a);
    expRom = ~a;
    for (int i = 0; i < 8; i++)
      if (validExp[i] && addrs[i] === a) expRom = datas[i];
  endfunction : expRom
  task automatic conclude();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // ==========================================================================
  // main sequence
  initial begin
    validExp = 8'h00;
    repeat (4) @(posedge mclk);
    #1 rst_b = 1;
    rdReg(RDPU_OFS_VALID, 32'h00000000);
    for (int i = 0; i < 8; i++) begin
      addrs[i] = $random(seed);
      datas[i] = $random(seed);
    end
    // corner: two entries cover one address
    addrs[6] = addrs[3];
    romRd(addrs[3]);
    for (int i = 0; i < 8; i++) begin
      wr(10'(8 * i), addrs[i]);
      rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
      wr(10'(8 * i + 4), datas[i]);
      validExp[i] = 1'b1;
      rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
      rdReg(10'(8 * i), addrs[i]);
      rdReg(10'(8 * i + 4), datas[i]);
    end
    for (int i = 0; i < 8; i++) romRd(addrs[i]);
    romRd(addrs[0] + 32'h00000004);
    wr(RDPU_OFS_DIS, 32'h00000040);
    validExp[6] = 1'b0;
    rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
    romRd(addrs[3]);
    wr(RDPU_OFS_ENA, 32'h00000040);
    validExp[6] = 1'b1;
    romRd(addrs[3]);
    // write just past the window would alias entry 0 on a short decode
    bus(1'b0, 1'b1, RDPU_LAST + 32'h00000001, 32'h00000000);
    rdReg(10'h000, addrs[0]);
    bus(1'b1, 1'b1, addrs[7], 32'h00000000);
    check(patchedRdata, romHrdata);
    // reads just below and just above the window must not alias onto entry 0
    bus(1'b0, 1'b0, RDPU_BASE - 32'h00000400, 32'h00000000);
    check(hrdata, 32'h00000000);
    bus(1'b0, 1'b0, RDPU_LAST + 32'h00000001, 32'h00000000);
    check(hrdata, 32'h00000000);
    // write-only, read-only and unmapped offsets
    rdReg(RDPU_OFS_DIS, 32'h00000000);
    rdReg(10'h3FC, 32'h00000000);
    wr(RDPU_OFS_VALID, 32'h00000000);
    rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
    // a lone data word swaps the patch word of a live entry
    datas[4] = ~datas[4];
    wr(10'h024, datas[4]);
    romRd(addrs[4]);
    // a fresh address word takes the entry out, and the enable strobe cannot revive a half pair
    wr(10'h028, addrs[5]);
    validExp[5] = 1'b0;
    wr(RDPU_OFS_ENA, 32'h00000020);
    rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
    romRd(addrs[5]);
    wr(10'h02C, datas[5]);
    validExp[5] = 1'b1;
    rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
    // random strobe masks, then every entry address looked up
    repeat (6) begin
      m = 8'($random(seed));
      wr(RDPU_OFS_DIS, {24'h000000, m});
      validExp = validExp & ~m;
      m = 8'($random(seed));
      wr(RDPU_OFS_ENA, {24'h000000, m});
      validExp = validExp | m;
      rdReg(RDPU_OFS_VALID, {24'h000000, validExp});
      for (int i = 0; i < 8; i++) romRd(addrs[i]);
    end
    // power cycle of the domain: every entry is lost and software loads what it needs again
    @(posedge mclk);
    #1 rst_b = 0;
    repeat (2) @(posedge mclk);
    #1 rst_b = 1;
    validExp = 8'h00;
    rdReg(RDPU_OFS_VALID, 32'h00000000);
    romRd(addrs[2]);
    addrs[0] = addrs[2];
    wr(10'h000, addrs[0]);
    wr(10'h004, datas[0]);
    validExp[0] = 1'b1;
    romRd(addrs[2]);
    conclude();
  end
endmodule : rom_data_patch_unit_bench
